// *** shared/txcs_pkg.sv ***
// Package: register map, field positions, reset values and carriers for the transmit status block
package txcs_pkg;

   // Register index 3; byte address is four times the index
   localparam logic [7:0]  TXCS_INDEX      = 8'h03;
   localparam logic [11:0] TXCS_ADDR       = 12'h00C;
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h010;
   localparam logic [11:0] IRQ_MASK_ADDR   = 12'h014;
   localparam logic [11:0] EVENT_ADDR      = 12'h018;

   // Field positions
   localparam int POS_PROGRAMMABLE_TX_INTERRUPT   = 15;
   localparam int POS_LCTSEL = 14;
   localparam int POS_FCSINH = 13;
   localparam int POS_EXDDIS = 12;
   localparam int POS_EXD    = 10;
   localparam int POS_DEF    = 9;
   localparam int POS_NOCRS  = 8;
   localparam int POS_CARRIER_LOST_FLAG   = 7;
   localparam int POS_EXC    = 6;
   localparam int POS_LATE   = 5;
   localparam int POS_PMB    = 3;
   localparam int POS_FU     = 2;
   localparam int POS_BCM    = 1;
   localparam int POS_OK     = 0;

   localparam logic [15:0] MODE_MASK     = 16'hF000;
   localparam logic [15:0] STATUS_MASK   = 16'h07EF;
   localparam logic [15:0] TXCS_RESET    = 16'h0101;
   localparam logic [15:0] START_CLEAR   = 16'h04C2;
   localparam logic [15:0] START_SET     = 16'h0100;
   localparam logic [15:0] WB_CLEAR      = 16'h0220;

   // Interrupt status bits
   localparam int IRQ_PROGRAMMABLE_TX_INTERRUPT  = 0;
   localparam int IRQ_DONE  = 1;
   localparam int IRQ_W     = 2;

   localparam logic [4:0] FCS_BYTES = 5'h04;

   // Descriptor-side carrier: start of packet
   typedef struct packed {
      logic        start;
      logic [15:0] config_word;
   } tx_start_t;

   // End-of-packet status carrier
   typedef struct packed {
      logic        done;
      logic [15:0] cond;
      logic [4:0]  collisions;
   } tx_end_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_TX   = 3'b010,
      ST_WB   = 3'b100
   } tx_state_t;

endpackage

// *** hdl/txcs_irq.sv ***
// Sticky interrupt status with mask and write-one-to-clear
`timescale 1ns/1ps
module txcs_irq
   import txcs_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [IRQ_W-1:0]  event_i,
   input  wire logic [IRQ_W-1:0]  clear_i,
   input  wire logic              mask_we_i,
   input  wire logic [IRQ_W-1:0]  mask_wdata_i,
   output logic      [IRQ_W-1:0]  status_o,
   output logic      [IRQ_W-1:0]  mask_o,
   output logic                   irq_o
);

   logic [IRQ_W-1:0] status_q;
   logic [IRQ_W-1:0] mask_q;

   genvar g;
   generate
      for (g = 0; g < IRQ_W; g++) begin : g_bit
         // Set beats clear so an event in the clear cycle is kept
         always_ff @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               status_q[g] <= 1'b0;
            end else if (event_i[g]) begin
               status_q[g] <= 1'b1;
            end else if (clear_i[g]) begin
               status_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_q <= '0;
      end else if (mask_we_i) begin
         mask_q <= mask_wdata_i;
      end
   end

   assign status_o = status_q;
   assign mask_o   = mask_q;
   assign irq_o    = |(status_q & mask_q);

endmodule

// *** hdl/txcs_apb.sv ***
// APB slave decode: strobes and registered read data
`timescale 1ns/1ps
module txcs_apb
   import txcs_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [15:0] txcs_i,
   input  wire logic [IRQ_W-1:0] irq_status_i,
   input  wire logic [IRQ_W-1:0] irq_mask_i,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic [31:0]      prdata_o,
   output logic             we_txcs_o,
   output logic             we_stat_o,
   output logic             we_mask_o,
   output logic             we_event_o
);

   logic        setup;
   logic        access;
   logic        hit;
   logic [31:0] rd_d;
   logic [31:0] prdata_q;

   // Data computed in setup, registered for the access cycle
   assign setup  = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign hit    = (paddr_i == TXCS_ADDR) | (paddr_i == IRQ_STATUS_ADDR)
                 | (paddr_i == IRQ_MASK_ADDR) | (paddr_i == EVENT_ADDR);

   always_comb begin
      rd_d = 32'h0000_0000;
      case (paddr_i)
         TXCS_ADDR:       rd_d = {16'h0000, txcs_i};
         IRQ_STATUS_ADDR: rd_d = {30'h0000_0000, irq_status_i};
         IRQ_MASK_ADDR:   rd_d = {30'h0000_0000, irq_mask_i};
         default:         rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && !pwrite_i) begin
         prdata_q <= rd_d;
      end
   end

   assign pready_o   = 1'b1;
   assign pslverr_o  = access & ~hit;
   assign prdata_o   = prdata_q;
   assign we_txcs_o  = access & pwrite_i & (paddr_i == TXCS_ADDR);
   assign we_stat_o  = access & pwrite_i & (paddr_i == IRQ_STATUS_ADDR);
   assign we_mask_o  = access & pwrite_i & (paddr_i == IRQ_MASK_ADDR);
   assign we_event_o = access & pwrite_i & (paddr_i == EVENT_ADDR);

endmodule

// *** hdl/txcs_top.sv ***
// Transmit control and status register with descriptor load and status write-back
// Overview of operation
// - At transmit start, copy config word bits 15..12 into the register.
// - At transmit end, set status bits 10..5 and 3..0 whose condition occurred.
// - At transmit end, write status and collision count to descriptor status.
// - After descriptor status write, clear deferred bit 9 and late-collision bit 5.
// - Next transmit start clears bits 10, 7, 6, 1 and sets bit 8.
// - Hardware reset sets bits 8 and 0, clears bit 1.
// - Software reset leaves the whole register unchanged.
// - Descriptor with interrupt bit set raises programmable transmit interrupt at once, only while register bit 15 is still clear.
// - Bit 14 selects where the late-collision timer starts.
// - Register holds all listed mode and status fields.
// - Timer select one starts the late-collision timer at first preamble bit.
// - FCS inhibit zero appends four FCS bytes; one omits them.
`timescale 1ns/1ps
module txcs_top
   import txcs_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic [31:0]      prdata_o,
   input  wire tx_start_t   tx_start_i,
   input  wire tx_end_t     tx_end_i,
   input  wire logic        soft_reset_i,
   output logic             wb_valid_o,
   output logic [15:0]      wb_status_o,
   output logic [4:0]       wb_collisions_o,
   input  wire logic        wb_ack_i,
   output logic             late_timer_at_preamble_o,
   output logic             excess_deferral_disable_o,
   output logic [4:0]       fcs_bytes_o,
   output logic             busy_o,
   output logic             irq_o
);

   logic [15:0]      txcs_q;
   logic [15:0]      txcs_d;
   tx_state_t        state_q;
   logic             wb_valid_q;
   logic [15:0]      wb_status_q;
   logic [4:0]       wb_coll_q;
   logic             we_txcs;
   logic             we_stat;
   logic             we_mask;
   logic             we_event;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic             start_ok;
   logic             end_ok;
   logic             wb_done;

   txcs_apb u_apb (
      .ref_clk_i    (ref_clk_i),
      .rstn_i       (rstn_i),
      .psel_i       (psel_i),
      .penable_i    (penable_i),
      .pwrite_i     (pwrite_i),
      .paddr_i      (paddr_i),
      .pwdata_i     (pwdata_i),
      .txcs_i       (txcs_q),
      .irq_status_i (irq_status),
      .irq_mask_i   (irq_mask),
      .pready_o     (pready_o),
      .pslverr_o    (pslverr_o),
      .prdata_o     (prdata_o),
      .we_txcs_o    (we_txcs),
      .we_stat_o    (we_stat),
      .we_mask_o    (we_mask),
      .we_event_o   (we_event)
   );

   assign start_ok = tx_start_i.start & (state_q == ST_IDLE);
   assign end_ok   = tx_end_i.done & (state_q == ST_TX);
   assign wb_done  = wb_valid_q & wb_ack_i;

   // Transmit sequencing
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_ok) begin
                  state_q <= ST_TX;
               end
            end
            ST_TX: begin
               if (end_ok) begin
                  state_q <= ST_WB;
               end
            end
            ST_WB: begin
               if (wb_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Register next value; software reset deliberately has no term here
   always_comb begin
      txcs_d = txcs_q;
      if (we_txcs) begin
         txcs_d = (txcs_q & ~MODE_MASK) | (pwdata_i[15:0] & MODE_MASK);
      end
      if (start_ok) begin
         txcs_d = (txcs_q & ~MODE_MASK) | (tx_start_i.config_word & MODE_MASK);
         txcs_d = (txcs_d & ~START_CLEAR) | START_SET;
      end
      if (end_ok) begin
         txcs_d = txcs_q | (tx_end_i.cond & STATUS_MASK);
      end
      if (wb_done) begin
         txcs_d = txcs_q & ~WB_CLEAR;
      end
      txcs_d = txcs_d & (MODE_MASK | STATUS_MASK);
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         txcs_q <= TXCS_RESET;
      end else begin
         txcs_q <= txcs_d;
      end
   end

   // Descriptor status write-back, held until acknowledged
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wb_valid_q  <= 1'b0;
         wb_status_q <= 16'h0000;
         wb_coll_q   <= 5'h00;
      end else if (end_ok) begin
         wb_valid_q  <= 1'b1;
         wb_status_q <= txcs_d;
         wb_coll_q   <= tx_end_i.collisions;
      end else if (wb_done) begin
         wb_valid_q  <= 1'b0;
      end
   end

   assign wb_valid_o      = wb_valid_q;
   assign wb_status_o     = wb_status_q;
   assign wb_collisions_o = wb_coll_q;

   // Mode outputs steering the transmitter
   assign late_timer_at_preamble_o  = txcs_q[POS_LCTSEL];
   assign excess_deferral_disable_o = txcs_q[POS_EXDDIS];
   assign fcs_bytes_o = txcs_q[POS_FCSINH] ? 5'h00 : FCS_BYTES;
   assign busy_o      = (state_q != ST_IDLE);

   // Interrupt raised from the descriptor word itself, without waiting for the load
   assign irq_event[IRQ_PROGRAMMABLE_TX_INTERRUPT] = start_ok & tx_start_i.config_word[POS_PROGRAMMABLE_TX_INTERRUPT]
                              & ~txcs_q[POS_PROGRAMMABLE_TX_INTERRUPT];
   assign irq_event[IRQ_DONE] = wb_done;

   txcs_irq u_irq (
      .ref_clk_i    (ref_clk_i),
      .rstn_i       (rstn_i),
      .event_i      (irq_event),
      .clear_i      (we_stat ? pwdata_i[IRQ_W-1:0] : {IRQ_W{1'b0}}),
      .mask_we_i    (we_mask),
      .mask_wdata_i (pwdata_i[IRQ_W-1:0]),
      .status_o     (irq_status),
      .mask_o       (irq_mask),
      .irq_o        (irq_o)
   );

   // Assertions
   hw_reset_a: assert property (@(posedge ref_clk_i) $rose(rstn_i)
      |-> txcs_q[8] && txcs_q[0] && !txcs_q[1])
      else $error("reset value wrong");
   mode_load_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      start_ok |=> txcs_q[15:12] == $past(tx_start_i.config_word[15:12]))
      else $error("mode bits not loaded");
   start_bits_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      start_ok |=> txcs_q[8] && !txcs_q[10] && !txcs_q[7] && !txcs_q[6] && !txcs_q[1])
      else $error("start clear/set wrong");
   end_status_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      end_ok |=> (txcs_q & $past(tx_end_i.cond) & STATUS_MASK)
                 == ($past(tx_end_i.cond) & STATUS_MASK))
      else $error("status not set");
   wb_issue_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      end_ok |=> wb_valid_o && wb_status_o == txcs_q
                 && wb_collisions_o == $past(tx_end_i.collisions))
      else $error("write-back wrong");
   wb_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wb_done |=> !txcs_q[9] && !txcs_q[5] && !wb_valid_o)
      else $error("bits 9/5 not cleared");
   soft_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      soft_reset_i && !we_txcs && !start_ok && !end_ok && !wb_done
      |=> $stable(txcs_q))
      else $error("register changed on soft reset");
   programmable_tx_interrupt_irq_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      start_ok && tx_start_i.config_word[15] && !txcs_q[15]
      |=> irq_status[IRQ_PROGRAMMABLE_TX_INTERRUPT])
      else $error("programmable irq missed");
   zero_bits_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !txcs_q[11] && !txcs_q[4])
      else $error("reserved bit set");
   fcs_len_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      fcs_bytes_o == (txcs_q[13] ? 5'h00 : 5'h04))
      else $error("fcs length wrong");
   timer_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      start_ok |=> late_timer_at_preamble_o == $past(tx_start_i.config_word[14]))
      else $error("timer select wrong");

endmodule

// *** verif/txcs_desc_model.sv ***
// Descriptor and memory side model: packet start, packet end, status write-back acknowledge
`timescale 1ns/1ps
module txcs_desc_model
   import txcs_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        wb_valid_i,
   input  wire logic [15:0] wb_status_i,
   input  wire logic [4:0]  wb_collisions_i,
   output tx_start_t        tx_start_o,
   output tx_end_t          tx_end_o,
   output logic             wb_ack_o
);
   logic [15:0] seen_status;
   logic [4:0]  seen_coll;

   initial begin
      tx_start_o = '0;
      tx_end_o = '0;
      wb_ack_o = 1'b0;
      seen_status = '0;
      seen_coll = '0;
   end

   // Words are inverted outside their strobe so a late sample shows up
   task automatic send(input logic [15:0] cfg, input logic [15:0] cond,
                       input logic [4:0] coll, input int dly);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      tx_start_o <= '{start: 1'b1, config_word: cfg};
      @(posedge ref_clk_i);
      tx_start_o <= '{start: 1'b0, config_word: ~cfg};
      repeat (2) @(posedge ref_clk_i);
      tx_end_o <= '{done: 1'b1, cond: cond, collisions: coll};
      @(posedge ref_clk_i);
      tx_end_o <= '{done: 1'b0, cond: ~cond, collisions: ~coll};
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wb_valid_i !== 1'b1 && n < 50);
      seen_status <= wb_status_i;
      seen_coll <= wb_collisions_i;
      // Slow memory: status write completes dly cycles later
      repeat (dly) @(posedge ref_clk_i);
      wb_ack_o <= 1'b1;
      @(posedge ref_clk_i);
      wb_ack_o <= 1'b0;
   endtask
endmodule

// *** verif/transmit_control_status_reg_tb.sv ***
// Self-checking bench for the transmit control and status register
`timescale 1ns/1ps
module transmit_control_status_reg_tb;
   import txcs_pkg::*;
   logic        ref_clk_i    = 1'b0;
   logic        rstn_i       = 1'b0;
   logic        psel_i       = 1'b0;
   logic        penable_i    = 1'b0;
   logic        pwrite_i     = 1'b0;
   logic [11:0] paddr_i      = 12'h000;
   logic [31:0] pwdata_i     = 32'h0;
   logic        soft_reset_i = 1'b0;
   logic        pready, pslverr, wb_valid, wb_ack, late_timer, exd_dis, busy, irq;
   logic [31:0] prdata, rd;
   logic [15:0] wb_status;
   logic [4:0]  wb_coll, fcs_bytes;
   logic        err;
   tx_start_t   tx_start;
   tx_end_t     tx_end;
   int          err_total = 0;
   int          n_checks  = 0;

   always #5 ref_clk_i = ~ref_clk_i;

   txcs_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .tx_start_i(tx_start),
      .tx_end_i(tx_end), .soft_reset_i(soft_reset_i), .wb_valid_o(wb_valid),
      .wb_status_o(wb_status), .wb_collisions_o(wb_coll), .wb_ack_i(wb_ack),
      .late_timer_at_preamble_o(late_timer), .excess_deferral_disable_o(exd_dis),
      .fcs_bytes_o(fcs_bytes), .busy_o(busy), .irq_o(irq));

   txcs_desc_model mem (.ref_clk_i(ref_clk_i), .wb_valid_i(wb_valid), .wb_status_i(wb_status),
      .wb_collisions_i(wb_coll), .tx_start_o(tx_start), .tx_end_o(tx_end), .wb_ack_o(wb_ack));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask

   // Leading edge keeps back-to-back calls from driving psel twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      err = pslverr;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   initial begin
      #200000;
      chk("watchdog", 32'h0, 32'h1);
      end_sim;
   end

   initial begin
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      rchk("txcs reset", TXCS_ADDR, 32'h0000_0101);
      rchk("irq status reset", IRQ_STATUS_ADDR, 32'h0);
      chk("fcs bytes reset", 32'(FCS_BYTES), 32'(fcs_bytes));
      apb(1'b1, TXCS_ADDR, 32'hFFFF_FFFF);
      rchk("txcs all ones", TXCS_ADDR, 32'h0000_F101);
      chk("timer select", 32'h1, 32'(late_timer));
      chk("fcs inhibited", 32'h0, 32'(fcs_bytes));
      apb(1'b1, TXCS_ADDR, 32'h0);
      rchk("txcs zero", TXCS_ADDR, 32'h0000_0101);
      apb(1'b1, 12'h020, 32'hFFFF_FFFF);
      chk("unmapped write err", 32'h1, 32'(err));
      rchk("unmapped read", 12'h020, 32'h0);
      chk("unmapped read err", 32'h1, 32'(err));
      apb(1'b1, IRQ_MASK_ADDR, 32'h1);
      mem.send(16'hA000, 16'h07EF, 5'h0A, 0);
      chk("wb status 1", 32'h0000_A7EF, 32'(mem.seen_status));
      chk("wb coll 1", 32'h0A, 32'(mem.seen_coll));
      rchk("txcs tx1", TXCS_ADDR, 32'h0000_A5CF);
      rchk("irq status tx1", IRQ_STATUS_ADDR, 32'h3);
      chk("irq unmasked", 32'h1, 32'(irq));
      apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
      rchk("irq after w1c", IRQ_STATUS_ADDR, 32'h2);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
      mem.send(16'h5000, 16'h0222, 5'h1F, 7);
      chk("wb status 2", 32'h0000_532F, 32'(mem.seen_status));
      chk("wb coll 2", 32'h1F, 32'(mem.seen_coll));
      rchk("txcs tx2", TXCS_ADDR, 32'h0000_510F);
      chk("timer select 2", 32'h1, 32'(late_timer));
      chk("deferral disable", 32'h1, 32'(exd_dis));
      chk("fcs appended", 32'(FCS_BYTES), 32'(fcs_bytes));
      rchk("irq status tx2", IRQ_STATUS_ADDR, 32'h2);
      soft_reset_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      rchk("txcs soft reset", TXCS_ADDR, 32'h0000_510F);
      soft_reset_i <= 1'b0;
      apb(1'b1, IRQ_STATUS_ADDR, 32'h3);
      mem.send(16'h8000, 16'h0000, 5'h00, 1);
      rchk("irq alternate", IRQ_STATUS_ADDR, 32'h3);
      apb(1'b1, IRQ_STATUS_ADDR, 32'h3);
      mem.send(16'h8000, 16'h0000, 5'h00, 0);
      rchk("irq repeated set", IRQ_STATUS_ADDR, 32'h2);
      chk("busy idle", 32'h0, 32'(busy));
      end_sim;
   end
endmodule
